// ---- src/bsfu_core.sv ----
// combinational result and flag logic of the bit shift and flag unit
`timescale 1ns/100ps
`default_nettype none
module bsfu_core (
	bsfu_op_if.core opb
);
	import bsfu_pkg::*;

	logic [DATA_W-1:0] sh;
	logic              c_out;

	// one case picks result and new flags; unlisted flags pass through
	always_comb begin
		sh = opb.rd_value;
		c_out = opb.status_in[FLAG_C];
		opb.result = opb.rd_value;
		opb.status_out = opb.status_in;
		opb.writes_reg = 1'b0;
		case (opb.op)
			rotate_right_carry_op: begin
				sh = {opb.status_in[FLAG_C], opb.rd_value[DATA_W-1:1]};
				c_out = opb.rd_value[0];
			end
			arith_shift_right_op: begin
				sh = {opb.rd_value[DATA_W-1], opb.rd_value[DATA_W-1:1]};
				c_out = opb.rd_value[0];
			end
			default: begin
				sh = opb.rd_value;
			end
		endcase
		case (opb.op)
			rotate_right_carry_op, arith_shift_right_op: begin
				opb.result = sh;
				opb.writes_reg = 1'b1;
				opb.status_out[FLAG_C] = c_out;
				opb.status_out[FLAG_Z] = (sh == 8'h00);
				opb.status_out[FLAG_N] = sh[DATA_W-1];
				// overflow is negative xor carry after the shift
				opb.status_out[FLAG_V] = sh[DATA_W-1] ^ c_out;
			end
			nibble_swap_op: begin
				opb.result = {opb.rd_value[3:0], opb.rd_value[7:4]};
				opb.writes_reg = 1'b1;
			end
			generic_flag_set_op:
				opb.status_out = bsfu_put_bit(opb.status_in, opb.bit_sel, 1'b1);
			generic_flag_clear_op:
				opb.status_out = bsfu_put_bit(opb.status_in, opb.bit_sel, 1'b0);
			bit_to_transfer_flag_op:
				opb.status_out[FLAG_T] = opb.rr_value[opb.bit_sel];
			transfer_flag_to_bit_op: begin
				opb.result = bsfu_put_bit(opb.rd_value, opb.bit_sel,
					opb.status_in[FLAG_T]);
				opb.writes_reg = 1'b1;
			end
			carry_set_op:          opb.status_out[FLAG_C] = 1'b1;
			carry_clear_op:        opb.status_out[FLAG_C] = 1'b0;
			negative_set_op:       opb.status_out[FLAG_N] = 1'b1;
			negative_clear_op:     opb.status_out[FLAG_N] = 1'b0;
			zero_set_op:           opb.status_out[FLAG_Z] = 1'b1;
			zero_clear_op:         opb.status_out[FLAG_Z] = 1'b0;
			global_irq_enable_op:  opb.status_out[FLAG_I] = 1'b1;
			global_irq_disable_op: opb.status_out[FLAG_I] = 1'b0;
			sign_set_op:           opb.status_out[FLAG_S] = 1'b1;
			sign_clear_op:         opb.status_out[FLAG_S] = 1'b0;
			overflow_set_op:       opb.status_out[FLAG_V] = 1'b1;
			overflow_clear_op:     opb.status_out[FLAG_V] = 1'b0;
			transfer_set_op:       opb.status_out[FLAG_T] = 1'b1;
			transfer_clear_op:     opb.status_out[FLAG_T] = 1'b0;
			default: begin
				opb.status_out = opb.status_in;
			end
		endcase
	end
endmodule
`default_nettype wire

// ---- src/bsfu_op_if.sv ----
// operation bundle between the unit's control and its combinational core
`timescale 1ns/100ps
`default_nettype none
interface bsfu_op_if;
	import bsfu_pkg::*;

	bsfu_op_e          op;
	logic [DATA_W-1:0] rd_value;
	logic [DATA_W-1:0] rr_value;
	logic [BIT_W-1:0]  bit_sel;
	logic [DATA_W-1:0] status_in;
	logic [DATA_W-1:0] result;
	logic [DATA_W-1:0] status_out;
	logic              writes_reg;

	modport ctrl (output op, rd_value, rr_value, bit_sel, status_in,
		input result, status_out, writes_reg);
	modport core (input op, rd_value, rr_value, bit_sel, status_in,
		output result, status_out, writes_reg);
endinterface
`default_nettype wire

// ---- src/bsfu_pkg.sv ----
// shared constants, types and helpers of the bit shift and flag unit
package bsfu_pkg;

	// datapath widths
	localparam int DATA_W = 8;
	localparam int BIT_W  = 3;
	localparam int ADDR_W = 8;

	// status register bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// register map, byte offsets
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] RESULT_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] COUNT_OFS  = 8'h08;

	// values after reset
	localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
	localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
	localparam logic [DATA_W-1:0] COUNT_RST  = 8'h00;
	localparam logic [DATA_W-1:0] UNMAPPED   = 8'h00;

	// operation codes driven by the decoder
	typedef enum logic [4:0] {
		no_op                   = 5'h00,
		rotate_right_carry_op   = 5'h01,
		arith_shift_right_op    = 5'h02,
		nibble_swap_op          = 5'h03,
		generic_flag_set_op     = 5'h04,
		generic_flag_clear_op   = 5'h05,
		bit_to_transfer_flag_op = 5'h06,
		transfer_flag_to_bit_op = 5'h07,
		carry_set_op            = 5'h08,
		carry_clear_op          = 5'h09,
		negative_set_op         = 5'h0A,
		negative_clear_op       = 5'h0B,
		zero_set_op             = 5'h0C,
		zero_clear_op           = 5'h0D,
		global_irq_enable_op    = 5'h0E,
		global_irq_disable_op   = 5'h0F,
		sign_set_op             = 5'h10,
		sign_clear_op           = 5'h11,
		overflow_set_op         = 5'h12,
		overflow_clear_op       = 5'h13,
		transfer_set_op         = 5'h14,
		transfer_clear_op       = 5'h15
	} bsfu_op_e;

	// write one bit of a byte, all others kept
	function automatic logic [DATA_W-1:0] bsfu_put_bit(input logic [DATA_W-1:0] v,
		input logic [BIT_W-1:0] idx, input logic b);
		logic [DATA_W-1:0] r;
		r = v;
		r[idx] = b;
		return r;
	endfunction

endpackage

// ---- src/bsfu_top.sv ----
// bit shift and flag unit: status register, result register and register port
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module bsfu_top (
	input  wire logic                    SYS_CLK,
	input  wire logic                    RESETN,
	input  wire logic                    OP_VALID,
	input  wire bsfu_pkg::bsfu_op_e      OP_CODE,
	input  wire logic [bsfu_pkg::DATA_W-1:0] RD_VALUE,
	input  wire logic [bsfu_pkg::DATA_W-1:0] RR_VALUE,
	input  wire logic [bsfu_pkg::BIT_W-1:0]  BIT_SEL,
	output logic [bsfu_pkg::DATA_W-1:0]      RESULT,
	output logic                             RESULT_WE,
	output logic [bsfu_pkg::DATA_W-1:0]      STATUS,
	input  wire logic [bsfu_pkg::ADDR_W-1:0] REG_ADDR,
	input  wire logic [bsfu_pkg::DATA_W-1:0] REG_WDATA,
	input  wire logic                        REG_WR,
	input  wire logic                        REG_RD,
	output logic [bsfu_pkg::DATA_W-1:0]      REG_RDATA
);
	import bsfu_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] status;
		logic [DATA_W-1:0] result;
		logic              result_we;
		logic [DATA_W-1:0] count;
		logic [DATA_W-1:0] rdata;
	} bsfu_state_s;

	bsfu_state_s st;
	bsfu_state_s next_st;
	logic [DATA_W-1:0] base_status;

	bsfu_op_if opb ();

	bsfu_core u_core (
		.opb (opb)
	);

	// a software write lands first, so an operation in the same cycle overrides its bits
	always_comb begin
		base_status = st.status;
		if (REG_WR && REG_ADDR == STATUS_OFS) begin
			base_status = REG_WDATA;
		end
	end

	// feed the core; an idle cycle runs no_op, which changes nothing
	assign opb.op        = OP_VALID ? OP_CODE : no_op;
	assign opb.rd_value  = RD_VALUE;
	assign opb.rr_value  = RR_VALUE;
	assign opb.bit_sel   = BIT_SEL;
	assign opb.status_in = base_status;

	// next state of everything the unit holds
	always_comb begin
		next_st = st;
		next_st.result_we = 1'b0;
		next_st.status = opb.status_out;
		if (OP_VALID && opb.writes_reg) begin
			next_st.result = opb.result;
			next_st.result_we = 1'b1;
		end
		if (OP_VALID) begin
			next_st.count = st.count + 8'h01; // wraps, counts operations taken
		end
		// read data stand only in the cycle after the strobe
		next_st.rdata = UNMAPPED;
		if (REG_RD) begin
			case (REG_ADDR)
				STATUS_OFS: next_st.rdata = st.status;
				RESULT_OFS: next_st.rdata = st.result;
				COUNT_OFS:  next_st.rdata = st.count;
				default:    next_st.rdata = UNMAPPED;
			endcase
		end
	end

	// state register
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			st.status <= STATUS_RST;
			st.result <= RESULT_RST;
			st.result_we <= 1'b0;
			st.count <= COUNT_RST;
			st.rdata <= UNMAPPED;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flip-flops
	assign RESULT    = st.result;
	assign RESULT_WE = st.result_we;
	assign STATUS    = st.status;
	assign REG_RDATA = st.rdata;
endmodule
`default_nettype wire

// ---- test/bsfu_chk.sv ----
// port checks of the bit shift and flag unit
`timescale 1ns/100ps
`default_nettype none
module bsfu_chk (
	input wire logic               SYS_CLK,
	input wire logic               RESETN,
	input wire logic               OP_VALID,
	input wire bsfu_pkg::bsfu_op_e OP_CODE,
	input wire logic [7:0]         RD_VALUE,
	input wire logic [2:0]         BIT_SEL,
	input wire logic [7:0]         RESULT,
	input wire logic               RESULT_WE,
	input wire logic [7:0]         STATUS,
	input wire logic               REG_WR
);
	import bsfu_pkg::*;
	default clocking dc @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);
	// one operation taken with no status write beside it
	sequence s_op(bsfu_op_e c);
		OP_VALID && !REG_WR && OP_CODE == c;
	endsequence
	// after a shift, Z N V follow the new value and new carry
	sequence s_shift_flags;
		STATUS[FLAG_Z] == (RESULT == 8'h00) && STATUS[FLAG_N] == RESULT[7]
			&& STATUS[FLAG_V] == (RESULT[7] ^ STATUS[FLAG_C]);
	endsequence
	ror_shift_a: assert property (s_op(rotate_right_carry_op) |=> RESULT_WE &&
		RESULT == {$past(STATUS[FLAG_C]), $past(RD_VALUE[7:1])}
		&& STATUS[FLAG_C] == $past(RD_VALUE[0])) else $error("rotate wrong");
	asr_shift_a: assert property (s_op(arith_shift_right_op) |=> RESULT_WE &&
		RESULT == {$past(RD_VALUE[7]), $past(RD_VALUE[7:1])}
		&& STATUS[FLAG_C] == $past(RD_VALUE[0])) else $error("shift wrong");
	shift_flags_a: assert property (OP_VALID && OP_CODE inside
		{rotate_right_carry_op, arith_shift_right_op} |=> s_shift_flags) else $error("shift flags");
	swap_keep_a: assert property (s_op(nibble_swap_op) |=> $stable(STATUS) &&
		RESULT == {$past(RD_VALUE[3:0]), $past(RD_VALUE[7:4])}) else $error("swap wrong");
	flag_set_a: assert property (s_op(generic_flag_set_op) |=>
		STATUS == ($past(STATUS) | (8'h01 << $past(BIT_SEL)))) else $error("flag set wrong");
	flag_clear_a: assert property (s_op(generic_flag_clear_op) |=>
		STATUS == ($past(STATUS) & ~(8'h01 << $past(BIT_SEL)))) else $error("flag clear wrong");
	bit_load_a: assert property (s_op(transfer_flag_to_bit_op) |=> RESULT_WE &&
		$stable(STATUS) && RESULT[$past(BIT_SEL)] == $past(STATUS[FLAG_T])) else $error("load");
	carry_set_a: assert property (s_op(carry_set_op) |=>
		STATUS == ($past(STATUS) | 8'h01)) else $error("carry set wrong");
	idle_quiet_a: assert property (!OP_VALID && !REG_WR |=>
		!RESULT_WE && $stable(STATUS)) else $error("idle cycle changed state");
endmodule
bind bsfu_top bsfu_chk i_chk (.*);
`default_nettype wire

// ---- test/bsfu_regfile.sv ----
// register file stand-in holding the destination register
`timescale 1ns/100ps
`default_nettype none
module bsfu_regfile (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       we,
	input  wire logic [7:0] wdata,
	input  wire logic       ld,
	input  wire logic [7:0] ld_val,
	output logic [7:0]      rd_value
);
	// write-back wins over a preload, as a real file would take the result
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rd_value <= 8'h00;
		else if (we)
			rd_value <= wdata;
		else if (ld)
			rd_value <= ld_val;
	end
endmodule
`default_nettype wire

// ---- test/bsfu_test.sv ----
// self-checking bench of the bit shift and flag unit
`timescale 1ns/100ps
`default_nettype none
module bsfu_test;
	import bsfu_pkg::*;
	logic       clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic       ld = 1'b0, result_we;
	bsfu_op_e   op_code = no_op;
	logic [2:0] bit_sel = 3'h0;
	logic [7:0] rr_value = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00, ld_val = 8'h00;
	logic [7:0] rd_value, result, status, reg_rdata, got, er, es;
	logic [7:0] st [3] = '{8'h00, 8'hFF, 8'h5A};
	logic [7:0] rd [3] = '{8'h01, 8'hA5, 8'h80};
	logic [7:0] rr [3] = '{8'h00, 8'h5A, 8'h10};
	logic [2:0] bs [3] = '{3'h0, 3'h7, 3'h4};
	int         failures = 0, comparisons = 0, cycles = 0;
	always #5 clk = ~clk;
	bsfu_top i_dut (.SYS_CLK(clk), .RESETN(rst_n), .OP_VALID(op_valid), .OP_CODE(op_code),
		.RD_VALUE(rd_value), .RR_VALUE(rr_value), .BIT_SEL(bit_sel), .RESULT(result),
		.RESULT_WE(result_we), .STATUS(status), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
	bsfu_regfile i_rf (.clk(clk), .rst_n(rst_n), .we(result_we), .wdata(result), .ld(ld),
		.ld_val(ld_val), .rd_value(rd_value));
	task automatic stop_test;
		$display("comparisons %0d, mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// preload the destination, then one operation; outputs settle 1 ns after
	task automatic do_op(input bsfu_op_e c, input logic [7:0] d, r, input logic [2:0] b);
		@(posedge clk);
		ld <= 1'b1;
		ld_val <= d;
		@(posedge clk);
		ld <= 1'b0;
		op_valid <= 1'b1;
		op_code <= c;
		rr_value <= r;
		bit_sel <= b;
		@(posedge clk);
		op_valid <= 1'b0;
		#1;
	endtask
	function automatic void expect_of(input bsfu_op_e c, input logic [7:0] d, r, s,
		input logic [2:0] b, output logic [7:0] res, output logic [7:0] ns);
		int fb [7] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I, FLAG_S, FLAG_V, FLAG_T};
		res = d;
		ns = s;
		case (c)
			rotate_right_carry_op:   res = {s[FLAG_C], d[7:1]};
			arith_shift_right_op:    res = {d[7], d[7:1]};
			nibble_swap_op:          res = {d[3:0], d[7:4]};
			generic_flag_set_op:     ns[b] = 1'b1;
			generic_flag_clear_op:   ns[b] = 1'b0;
			bit_to_transfer_flag_op: ns[FLAG_T] = r[b];
			transfer_flag_to_bit_op: res[b] = s[FLAG_T];
			default: if (c >= carry_set_op && c <= transfer_clear_op) ns[fb[(c - 8) / 2]] = ~c[0];
		endcase
		if (c == rotate_right_carry_op || c == arith_shift_right_op) begin
			ns[FLAG_C] = d[0];
			ns[FLAG_Z] = (res == 8'h00);
			ns[FLAG_N] = res[7];
			ns[FLAG_V] = res[7] ^ d[0];
		end
	endfunction
	// a hang ends the run as a mismatch
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			stop_test;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		bus_wr(STATUS_OFS, 8'h81);
		bus_rd(STATUS_OFS, got);
		chk("status rw", 8'h81, got);
		// read data must fall back to zero one cycle after they stood
		@(posedge clk);
		#1 chk("rdata drop", UNMAPPED, reg_rdata);
		bus_wr(RESULT_OFS, 8'h3C);
		bus_rd(RESULT_OFS, got);
		chk("result ro", RESULT_RST, got);
		bus_rd(8'h10, got);
		chk("unmapped", UNMAPPED, got);
		$display("test registers done");
		// every code except no_op, plus one unused, on three status and operand sets
		for (int v = 0; v < 3; v++) begin
			for (int k = 1; k <= 22; k++) begin
				bus_wr(STATUS_OFS, st[v]);
				do_op(bsfu_op_e'(k), rd[v], rr[v], bs[v]);
				expect_of(bsfu_op_e'(k), rd[v], rr[v], st[v], bs[v], er, es);
				chk("status", es, status);
				chk("write pulse", {7'h00, k inside {1, 2, 3, 7}}, {7'h00, result_we});
				if (k inside {1, 2, 3, 7}) begin
					chk("result", er, result);
					@(posedge clk);
					#1 chk("write-back", er, rd_value);
				end
			end
			$display("test vector %0d done", v);
		end
		bus_rd(COUNT_OFS, got);
		chk("op count", 8'h42, got);
		stop_test;
	end
endmodule
`default_nettype wire
